// ### verilog/bdos_pkg.sv
// Purpose: Shared constants for the buffered converter output sequencer
// Assumes: APB register access, 32-bit data, one aligned word per register
// Notes:   Offsets are byte addresses
package bdos_pkg;
	localparam int CH_NUM   = 4;
	localparam int DATA_W   = 16;
	localparam int DEPTH    = 16;
	localparam int PTR_W    = 4;
	localparam int CNT_W    = 5;
	localparam int RATE_W   = 24;

	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_BUFOPS = 8'h04;
	localparam logic [7:0] OFS_RATE   = 8'h08;
	localparam logic [7:0] OFS_DATA   = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;

	// Board control word fields
	localparam int CTRL_BUF_EN  = 0;
	localparam int CTRL_SIMUL   = 1;
	localparam int CTRL_RATE_EN = 2;
	localparam int CTRL_TWOS    = 3;

	// Buffer operations fields
	localparam int OPS_INT_CLK = 0;
	localparam int OPS_CLK_EN  = 1;
	localparam int OPS_FLUSH   = 2;
	localparam int OPS_CIRC    = 3;
	localparam int OPS_SW_CLK  = 4;
	localparam int OPS_MASK_LO = 8;

	// Status fields
	localparam int STS_CNT_LO = 0;
	localparam int STS_EMPTY  = 8;
	localparam int STS_FULL   = 9;
	localparam int STS_LAST   = 12;

	localparam logic [RATE_W-1:0] RATE_RST = 24'h00007E;
	localparam logic [CH_NUM-1:0] MASK_RST = 4'hF;
	localparam logic [DATA_W-1:0] MSB_FLIP = 16'h8000;
endpackage

// ### verilog/bdos_top.sv
// Purpose: Buffered converter output sequencer with APB register access
// Assumes: Host keeps buffer between empty and full in continuous generation
// Notes:   Buffer is flip-flop storage; outputs hold when nothing is due
`timescale 1ns/1ps
module bdos_top (
	input  wire  logic                          clock,
	input  wire  logic                          rst_b,
	input  wire  logic                          psel,
	input  wire  logic                          penable,
	input  wire  logic                          pwrite,
	input  wire  logic [7:0]                    paddr,
	input  wire  logic [31:0]                   pwdata,
	output logic [31:0]                         prdata,
	output logic                                pready,
	output logic                                pslverr,
	input  wire  logic                          ext_clk_pin,
	output logic [bdos_pkg::DATA_W-1:0]         dac_value [bdos_pkg::CH_NUM],
	output logic [bdos_pkg::CH_NUM-1:0]         dac_update
);
	import bdos_pkg::*;

	function automatic logic [2:0] count_active(input logic [CH_NUM-1:0] m);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 0; i < CH_NUM; i++) begin
			n = n + {2'h0, m[i]};
		end
		return n;
	endfunction
	// Position of a channel inside its group: active channels below it
	function automatic logic [2:0] slot_of(input logic [CH_NUM-1:0] m, input int ch);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 0; i < CH_NUM; i++) begin
			if (i < ch)
				n = n + {2'h0, m[i]};
		end
		return n;
	endfunction
	function automatic logic [PTR_W-1:0] ptr_add(input logic [PTR_W-1:0] p,
		input logic [2:0] k);
		return PTR_W'(p + {1'h0, k});
	endfunction
	// Lowest active channel above the last one, wrapping round
	function automatic logic [1:0] next_chan(input logic [CH_NUM-1:0] m,
		input logic [1:0] last);
		logic [1:0] r;
		logic       hit;
		r = last;
		hit = 1'b0;
		for (int i = 1; i <= CH_NUM; i++) begin
			if (!hit && m[2'(last + 2'(i))]) begin
				r = 2'(last + 2'(i));
				hit = 1'b1;
			end
		end
		return r;
	endfunction

	logic [3:0]              ctrl_reg;
	logic                    int_clk_reg;
	logic                    clk_en_reg;
	logic                    circ_reg;
	logic [CH_NUM-1:0]       mask_reg;
	logic [RATE_W-1:0]       rate_reg;
	logic                    flush_reg;
	logic                    sw_clk_reg;
	logic [DATA_W-1:0]       mem_reg [DEPTH];
	logic [PTR_W-1:0]        rd_ptr_reg;
	logic [PTR_W-1:0]        wr_ptr_reg;
	logic [CNT_W-1:0]        count_reg;
	logic [1:0]              last_ch_reg;
	logic [RATE_W-1:0]       div_cnt_reg;
	logic                    ext_s1_reg;
	logic                    ext_s2_reg;
	logic                    ext_s3_reg;
	logic                    ext_level_reg;
	logic [31:0]             prdata_reg;
	logic                    pslverr_reg;

	logic                    wr_acc;
	logic                    setup;
	logic                    simul;
	logic                    empty;
	logic                    full;
	logic [2:0]              n_act;
	logic [2:0]              pop_n;
	logic                    grp_ready;
	logic                    pop;
	logic                    push;
	logic                    rate_tick;
	logic                    ext_fall;
	logic                    out_tick;
	logic [1:0]              seq_ch;

	assign pready  = 1'b1;
	assign prdata  = prdata_reg;
	assign pslverr = pslverr_reg;
	assign setup   = psel && !penable;
	assign wr_acc  = psel && penable && pwrite;
	assign simul   = ctrl_reg[CTRL_SIMUL];
	assign empty   = (count_reg == '0);
	assign full    = (count_reg == CNT_W'(DEPTH));

	always_comb begin
		n_act = count_active(mask_reg);
		seq_ch = next_chan(mask_reg, last_ch_reg);
		pop_n = simul ? n_act : 3'h1;
		// Whole group present for simultaneous, any word for sequential
		grp_ready = (n_act != 3'h0) && (count_reg >= {2'h0, pop_n});
		pop = out_tick && grp_ready;
		push = wr_acc && (paddr == OFS_DATA) && !full && !circ_reg;
	end

	// Rate divider, restarts whenever it is stopped
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			div_cnt_reg <= '0;
		end else if (!(clk_en_reg && ctrl_reg[CTRL_RATE_EN]) || rate_tick) begin
			div_cnt_reg <= '0;
		end else begin
			div_cnt_reg <= div_cnt_reg + RATE_W'(1);
		end
	end
	assign rate_tick = clk_en_reg && ctrl_reg[CTRL_RATE_EN]
		&& ((div_cnt_reg + RATE_W'(1)) >= rate_reg);

	// External clock pin: three stages, change accepted when stages two and three agree
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ext_s1_reg <= 1'b1;
			ext_s2_reg <= 1'b1;
			ext_s3_reg <= 1'b1;
			ext_level_reg <= 1'b1;
		end else begin
			ext_s1_reg <= ext_clk_pin;
			ext_s2_reg <= ext_s1_reg;
			ext_s3_reg <= ext_s2_reg;
			if (ext_s2_reg == ext_s3_reg)
				ext_level_reg <= ext_s3_reg;
		end
	end
	assign ext_fall = ext_level_reg && !ext_s3_reg && (ext_s2_reg == ext_s3_reg);

	assign out_tick = ctrl_reg[CTRL_BUF_EN] && (sw_clk_reg
		|| (clk_en_reg && ctrl_reg[CTRL_RATE_EN]
		&& (int_clk_reg ? rate_tick : ext_fall)));

	// Register writes
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg <= 4'h0;
			int_clk_reg <= 1'b0;
			clk_en_reg <= 1'b0;
			circ_reg <= 1'b0;
			mask_reg <= MASK_RST;
			rate_reg <= RATE_RST;
			flush_reg <= 1'b0;
			sw_clk_reg <= 1'b0;
		end else begin
			flush_reg <= 1'b0;
			sw_clk_reg <= 1'b0;
			if (wr_acc && paddr == OFS_CTRL)
				ctrl_reg <= pwdata[3:0];
			if (wr_acc && paddr == OFS_BUFOPS) begin
				int_clk_reg <= pwdata[OPS_INT_CLK];
				clk_en_reg <= pwdata[OPS_CLK_EN];
				circ_reg <= pwdata[OPS_CIRC];
				mask_reg <= pwdata[OPS_MASK_LO +: CH_NUM];
				flush_reg <= pwdata[OPS_FLUSH];
				sw_clk_reg <= pwdata[OPS_SW_CLK];
			end
			if (wr_acc && paddr == OFS_RATE)
				rate_reg <= pwdata[RATE_W-1:0];
		end
	end

	// Buffer storage; only the low data bits are kept, markers above are dropped
	always_ff @(posedge clock) begin
		if (push)
			mem_reg[wr_ptr_reg] <= pwdata[DATA_W-1:0];
		if (pop && circ_reg) begin
			for (int k = 0; k < CH_NUM; k++) begin
				if (3'(k) < pop_n)
					mem_reg[ptr_add(wr_ptr_reg, 3'(k))] <= mem_reg[ptr_add(rd_ptr_reg, 3'(k))];
			end
		end
	end

	// Buffer pointers and fill count
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rd_ptr_reg <= '0;
			wr_ptr_reg <= '0;
			count_reg <= '0;
		end else if (flush_reg) begin
			rd_ptr_reg <= '0;
			wr_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (pop)
				rd_ptr_reg <= ptr_add(rd_ptr_reg, pop_n);
			wr_ptr_reg <= ptr_add(wr_ptr_reg, (pop && circ_reg ? pop_n : 3'h0)
				+ {2'h0, push});
			count_reg <= count_reg + {4'h0, push}
				- ((pop && !circ_reg) ? {2'h0, pop_n} : 5'h00);
		end
	end

	// Converter channel values; coding option converts two's complement to offset binary
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			for (int ch = 0; ch < CH_NUM; ch++) begin
				dac_value[ch] <= '0;
			end
			dac_update <= '0;
			last_ch_reg <= 2'(CH_NUM - 1);
		end else begin
			dac_update <= '0;
			if (flush_reg)
				last_ch_reg <= 2'(CH_NUM - 1);
			else if (pop && !simul)
				last_ch_reg <= seq_ch;
			for (int ch = 0; ch < CH_NUM; ch++) begin
				if (pop && simul && mask_reg[ch]) begin
					dac_value[ch] <= mem_reg[ptr_add(rd_ptr_reg, slot_of(mask_reg, ch))]
						^ (ctrl_reg[CTRL_TWOS] ? MSB_FLIP : '0);
					dac_update[ch] <= 1'b1;
				end else if (pop && !simul && seq_ch == 2'(ch)) begin
					dac_value[ch] <= mem_reg[rd_ptr_reg]
						^ (ctrl_reg[CTRL_TWOS] ? MSB_FLIP : '0);
					dac_update[ch] <= 1'b1;
				end
			end
		end
	end

	// APB read data and error, captured in the setup phase
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			prdata_reg <= '0;
			pslverr_reg <= 1'b0;
		end else if (setup) begin
			prdata_reg <= '0;
			pslverr_reg <= 1'b0;
			unique case (paddr)
				OFS_CTRL:   prdata_reg <= {28'h0, ctrl_reg};
				OFS_BUFOPS: prdata_reg <= {20'h0, mask_reg, 4'h0, circ_reg, 1'b0,
					clk_en_reg, int_clk_reg};
				OFS_RATE:   prdata_reg <= {8'h00, rate_reg};
				OFS_DATA:   pslverr_reg <= pwrite && (full || circ_reg);
				OFS_STATUS: begin
					prdata_reg[STS_CNT_LO +: CNT_W] <= count_reg;
					prdata_reg[STS_EMPTY] <= empty;
					prdata_reg[STS_FULL] <= full;
					prdata_reg[STS_LAST +: 2] <= last_ch_reg;
				end
				default:    pslverr_reg <= 1'b1;
			endcase
		end
	end

	property p_flush;
		@(posedge clock) disable iff (!rst_b) flush_reg |=> (count_reg == 5'h00);
	endproperty
	a_flush: assert property (p_flush) else $error("flush left data");
	property p_empty_hold;
		@(posedge clock) disable iff (!rst_b)
		(out_tick && empty) |=> (dac_update == 4'h0) && $stable(rd_ptr_reg);
	endproperty
	a_empty_hold: assert property (p_empty_hold) else $error("output changed on empty");
	property p_group;
		@(posedge clock) disable iff (!rst_b)
		(out_tick && simul && n_act != 3'h0 && count_reg >= {2'h0, n_act})
		|=> (dac_update == $past(mask_reg));
	endproperty
	a_group: assert property (p_group) else $error("group not updated together");
	property p_partial;
		@(posedge clock) disable iff (!rst_b)
		(simul && count_reg < {2'h0, n_act}) |=> (dac_update == 4'h0);
	endproperty
	a_partial: assert property (p_partial) else $error("partial group changed output");
	property p_seq_one;
		@(posedge clock) disable iff (!rst_b)
		(pop && !simul) |=> $onehot(dac_update) && last_ch_reg == $past(seq_ch);
	endproperty
	a_seq_one: assert property (p_seq_one) else $error("sequential update not single");
	property p_queue;
		@(posedge clock) disable iff (!rst_b)
		(push && !pop && !flush_reg) |=> (count_reg == $past(count_reg) + 5'h01);
	endproperty
	a_queue: assert property (p_queue) else $error("write not queued");
	property p_gate;
		@(posedge clock) disable iff (!rst_b)
		!(clk_en_reg && ctrl_reg[CTRL_RATE_EN]) && !sw_clk_reg |-> !out_tick;
	endproperty
	a_gate: assert property (p_gate) else $error("clock ran while gated");
	property p_int_src;
		@(posedge clock) disable iff (!rst_b)
		(ctrl_reg[CTRL_BUF_EN] && int_clk_reg && rate_tick) |-> out_tick;
	endproperty
	a_int_src: assert property (p_int_src) else $error("divider tick lost");
	property p_buf_en;
		@(posedge clock) disable iff (!rst_b)
		!ctrl_reg[CTRL_BUF_EN] |=> (dac_update == 4'h0);
	endproperty
	a_buf_en: assert property (p_buf_en) else $error("update while disabled");
	property p_circ;
		@(posedge clock) disable iff (!rst_b)
		(pop && circ_reg && !flush_reg) |=> $stable(count_reg);
	endproperty
	a_circ: assert property (p_circ) else $error("circular buffer lost data");
endmodule // bdos_top

// ### tb/bdos_conv_model.sv
// Purpose: Converter side of the sequencer: latches codes, makes the clock pin
// Assumes: Pin idles high and stands still between requested falls
// Notes:   The bench asks for each fall through the fall task
`timescale 1ns/1ps
module bdos_conv_model (
	input  wire logic                          clock,
	input  wire logic                          rst_b,
	input  wire logic [bdos_pkg::DATA_W-1:0]   dac_value [bdos_pkg::CH_NUM],
	input  wire logic [bdos_pkg::CH_NUM-1:0]   dac_update,
	output logic                               ext_clk_pin
);
	import bdos_pkg::*;
	logic [DATA_W-1:0] held [CH_NUM];

	initial ext_clk_pin = 1'b1;

	// Each channel keeps its own last code
	always @(posedge clock or negedge rst_b) begin
		for (int i = 0; i < CH_NUM; i++) begin
			if (!rst_b)
				held[i] <= '0;
			else if (dac_update[i])
				held[i] <= dac_value[i];
		end
	end

	// One falling edge, low for the given cycles
	task automatic fall(input int low);
		@(posedge clock);
		ext_clk_pin <= 1'b0;
		repeat (low) @(posedge clock);
		ext_clk_pin <= 1'b1;
	endtask
endmodule // bdos_conv_model

// ### tb/tb_buffered_dac_output_sequencer.sv
// Purpose: Self-checking bench of the buffered converter output sequencer
// Assumes: Zero wait APB slave; software clock ticks one edge after its write
// Notes:   Random words use all 32 bits; only the low half may reach outputs
`timescale 1ns/1ps
module tb_buffered_dac_output_sequencer;
	import bdos_pkg::*;
	logic              clock, rst_b, psel, penable, pwrite, pready, pslverr, ext_clk_pin, e;
	logic [7:0]        paddr;
	logic [31:0]       pwdata, prdata, r, ops;
	logic [DATA_W-1:0] dac_value [CH_NUM];
	logic [CH_NUM-1:0] dac_update, first;
	logic [31:0]       d [4];
	int                errors, n_tests, k, t;

	bdos_top i_dut (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_clk_pin(ext_clk_pin), .dac_value(dac_value),
		.dac_update(dac_update));
	bdos_conv_model i_conv (.clock(clock), .rst_b(rst_b), .dac_value(dac_value),
		.dac_update(dac_update), .ext_clk_pin(ext_clk_pin));

	always #5 clock = ~clock;

	function automatic logic [15:0] code(input logic [31:0] w, input logic twos);
		return twos ? (w[15:0] ^ MSB_FLIP) : w[15:0];
	endfunction

	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
			errors++;
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		apb(1'b1, a, wd);
	endtask

	task automatic watch(input int n);
		first = '0;
		k = 0;
		repeat (n) begin
			@(negedge clock);
			if (dac_update !== '0) begin
				if (k == 0)
					first = dac_update;
				k++;
			end
		end
	endtask

	task automatic swclk;
		wr(OFS_BUFOPS, ops | 32'h10);
		watch(6);
	endtask

	task automatic load(input int n);
		for (int j = 0; j < n; j++) begin
			d[j] = $urandom;
			wr(OFS_DATA, d[j]);
		end
	endtask

	initial begin
		clock = 1'b0;
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		errors = 0;
		n_tests = 0;
		ops = 32'h0F00;
		t = $urandom(32'h1E55B488);
		repeat (4) @(posedge clock);
		rst_b <= 1'b1;
		apb(1'b0, OFS_CTRL, 0);
		chk("ctrl", 32'h0, r);
		apb(1'b0, OFS_BUFOPS, 0);
		chk("bufops", 32'h0F00, r);
		apb(1'b0, OFS_RATE, 0);
		chk("rate", {8'h00, RATE_RST}, r);
		apb(1'b0, OFS_STATUS, 0);
		chk("status", 32'h100, r & 32'h3FF);
		apb(1'b0, 8'h20, 0);
		chk("unmapped", 32'h1, {31'h0, e});
		$display("test reset done");
		wr(OFS_CTRL, 32'h1);
		wr(OFS_BUFOPS, ops | 32'h4);
		load(4);
		apb(1'b0, OFS_STATUS, 0);
		chk("queued", 32'h4, r & 32'h1F);
		for (int i = 0; i < 4; i++) begin
			swclk();
			chk("seq channel", 32'h1 << i, {28'h0, first});
			chk("seq pulses", 32'h1, k);
			chk("seq code", {16'h0, code(d[i], 1'b0)}, {16'h0, i_conv.held[i]});
		end
		swclk();
		chk("empty tick", 32'h0, k);
		$display("test sequential done");
		wr(OFS_CTRL, 32'hB);
		wr(OFS_BUFOPS, ops | 32'h4);
		repeat (2) begin
			load(3);
			swclk();
			chk("partial group", 32'h0, k);
			d[3] = $urandom;
			wr(OFS_DATA, d[3]);
			swclk();
			chk("group mask", 32'hF, {28'h0, first});
			chk("group pulses", 32'h1, k);
			for (int i = 0; i < 4; i++)
				chk("group code", {16'h0, code(d[i], 1'b1)}, {16'h0, i_conv.held[i]});
		end
		$display("test simultaneous done");
		wr(OFS_CTRL, 32'h1);
		load(2);
		wr(OFS_BUFOPS, ops | 32'h4);
		apb(1'b0, OFS_STATUS, 0);
		chk("flushed", 32'h100, r & 32'h3FF);
		swclk();
		chk("flushed tick", 32'h0, k);
		wr(OFS_CTRL, 32'h0);
		load(1);
		swclk();
		chk("outputs off", 32'h0, k);
		ops = 32'h0400;
		wr(OFS_CTRL, 32'h1);
		wr(OFS_BUFOPS, ops | 32'h4);
		load(1);
		swclk();
		chk("single channel", 32'h4, {28'h0, first});
		chk("single code", {16'h0, code(d[0], 1'b0)}, {16'h0, i_conv.held[2]});
		$display("test flush and mask done");
		ops = 32'h0F03;
		wr(OFS_RATE, 32'h5);
		wr(OFS_BUFOPS, 32'h0F04);
		load(3);
		wr(OFS_BUFOPS, ops);
		watch(20);
		chk("gate without rate", 32'h0, k);
		wr(OFS_CTRL, 32'h5);
		t = 0;
		while (dac_update === '0 && t < 50) begin
			@(negedge clock);
			t++;
		end
		t = 0;
		do begin
			@(negedge clock);
			t++;
		end while (dac_update === '0 && t < 50);
		chk("divider period", 32'h5, t);
		ops = 32'h0F02;
		wr(OFS_BUFOPS, ops | 32'h4);
		load(1);
		watch(10);
		chk("pin idle", 32'h0, k);
		i_conv.fall(3);
		watch(10);
		chk("pin fall", 32'h1, {28'h0, first});
		chk("pin code", {16'h0, code(d[0], 1'b0)}, {16'h0, i_conv.held[0]});
		$display("test clock sources done");
		ops = 32'h0F00;
		wr(OFS_BUFOPS, ops | 32'h4);
		for (int j = 0; j < DEPTH; j++)
			wr(OFS_DATA, $urandom);
		wr(OFS_DATA, 32'h1234);
		chk("full refuse", 32'h1, {31'h0, e});
		apb(1'b0, OFS_STATUS, 0);
		chk("full status", 32'h210, r & 32'h3FF);
		wr(OFS_BUFOPS, ops | 32'h4);
		load(2);
		ops = 32'h0F08;
		wr(OFS_BUFOPS, ops);
		for (int i = 0; i < 4; i++) begin
			swclk();
			chk("circular code", {16'h0, code(d[i % 2], 1'b0)}, {16'h0, i_conv.held[i]});
		end
		apb(1'b0, OFS_STATUS, 0);
		chk("circular count", 32'h2, r & 32'h1F);
		wr(OFS_DATA, 32'h1234);
		chk("circular refuse", 32'h1, {31'h0, e});
		$display("test circular done");
		stop_test();
	end

	initial begin
		#50000;
		errors++;
		stop_test();
	end
endmodule // tb_buffered_dac_output_sequencer
